/* src/srch_dev.sv */
// Search engine end: registers, storage, cascade and SRAM bus.
// Notes on behaviour
// - Drive shared 24-bit SRAM address bus.
// - Only one engine drives shared SRAM controls.
// - Only default driver drives SRAM output enable.
// - Latch enable low exactly with valid address.
// - Seven local-hit inputs; input zero unused.
// - Two local-hit outputs feed downstream engines.
// - Last block engine drives 3-bit block hit.
// - Four-block cascade: last block seven engines.
// - Full outputs only when all entries full.
// - Table-full flag when whole cascade full.
// - 4-bit position code; 1111 means broadcast.
// - Broadcast read answered only by last member.
// - Select low: divide double-rate clock by phase.
// - Select high: doubled clock halved internally.
// - Host holds reset through lock, then waits.
// - Single-rate mode samples inputs at double rate.
// - Registers 72 bits wide, two banks.
// - Fixed register address decode map.
// - Search stores cycle A even, B odd.
// - Mask index n picks registers 2n, 2n+1.
// - Search mask one compares, zero matches.
// - Write mask one writes, zero keeps bit.
// - Host loads even and odd masks equal.
// - Control register bit 8 makes SRAM default driver.
//
// Our own choice: the address-and-strobe port.
module srch_dev #(
   parameter int               DEPTH        = 8,
   parameter logic [6:0]       FULL_IN_MASK = 7'h00,
   parameter bit               LAST_IN_BLK  = 1'b1,
   parameter logic [31:0]      DEVICE_INFORMATION_ID      = 32'h0000_0001 // Arbitrary identification value.
) (
   // Clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_sys_rst,
   // Host link
   srch_if.dev                    bus,
   // Cascade inputs
   input  wire logic [4:0]        i_position,
   input  wire logic [6:0]        i_local_hit_in,
   input  wire logic [2:0]        i_block_hit_in,
   input  wire logic [6:0]        i_full_chain_in,
   // Cascade outputs
   output logic [1:0]             o_local_hit_out,
   output logic [2:0]             o_block_hit_out,
   output logic [1:0]             o_full_chain_out,
   output logic                   o_table_full,
   // SRAM bus
   output logic [srch_pkg::SA_W-1:0] o_sram_addr_out,
   output logic                   o_sram_ce_n,
   output logic                   o_sram_we_n,
   output logic                   o_sram_ale_n,
   output logic                   o_sram_bus_oe,
   output logic                   o_sram_oe_n,
   output logic                   o_sram_oe_n_oe,
   // Internal clock phase
   output logic                   o_int_clk
);
   localparam int W  = srch_pkg::W;
   localparam int IW = $clog2(DEPTH);

   logic          rst;
   logic          cv_r, pend_r;
   logic [10:0]   cmd_r, op_r;
   logic [W-1:0]  dq_r, a_r;
   logic [4:0]    pos_r;
   logic [6:0]    lhi_r, fi_r;
   logic [2:0]    bhi_r;
   logic [W-1:0]  cmp_r [2][32];
   logic [W-1:0]  msk_r [2][32];
   logic [W-1:0]  hit_r [2][8];
   logic [W-1:0]  ctl_r [2];
   logic [W-1:0]  brd_r [2];
   logic [W-1:0]  bwr_r [2];
   logic [W-1:0]  ent_r [DEPTH];
   logic [W-1:0]  dqo_r;
   logic          dqoe_r, ack_r;
   logic [DEPTH-1:0] hitv, fb;
   logic [IW-1:0] fidx, nidx;
   logic [W-1:0]  m_even, rdv;
   logic          bk, sel, bc, any_hit, winner, own_full, en, drv, rsp;
   logic [1:0]    code;
   logic [6:0]    ad;

   assign rst = i_sys_rst || !bus.rst_n;

   // ---------------------------------------------------------------------
   // Input sampling and command phases
   // ---------------------------------------------------------------------
   // All inputs are captured on the core clock.
   always_ff @(posedge i_core_clk) begin
      cv_r  <= bus.cmd_v;
      cmd_r <= bus.cmd;
      dq_r  <= bus.dq;
      pos_r <= i_position;
      lhi_r <= i_local_hit_in;
      bhi_r <= i_block_hit_in;
      fi_r  <= i_full_chain_in;
   end

   // Cycle A opens a command; cycle B follows and executes.
   always_ff @(posedge i_core_clk) begin
      if (rst) begin
         pend_r <= 1'b0;
         op_r   <= '0;
         a_r    <= '0;
      end else begin
         pend_r <= cv_r && !pend_r;
         if (cv_r && !pend_r) begin
            op_r <= cmd_r;
            a_r  <= dq_r;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Decode of the executing command
   // ---------------------------------------------------------------------
   assign bk     = op_r[10];
   assign code   = op_r[1:0];
   assign ad     = a_r[6:0];
   assign bc     = a_r[srch_pkg::F_ID+:4] == srch_pkg::BCAST;
   assign sel    = bc || (a_r[srch_pkg::F_ID+:4] == pos_r[4:1]);
   assign m_even = msk_r[bk][{op_r[5:2], 1'b0}];
   assign en     = ctl_r[0][srch_pkg::B_EN] || ctl_r[1][srch_pkg::B_EN];
   assign drv    = ctl_r[0][srch_pkg::B_DRV] || ctl_r[1][srch_pkg::B_DRV];
   assign rsp    = pend_r && code == srch_pkg::C_RD && sel && (!bc || ctl_r[bk][srch_pkg::B_LAST]);

   // Per-entry masked compare and full bits.
   genvar g;
   for (g = 0; g < DEPTH; g++) begin : g_ent
      assign hitv[g] = ((ent_r[g] ^ a_r) & m_even) == '0;
      assign fb[g]   = ent_r[g][0];
   end
   assign own_full = &fb;
   assign any_hit  = |hitv;
   // Upstream hits take priority.
   assign winner   = pend_r && code == srch_pkg::C_SR && any_hit && !(|lhi_r[6:1]) && !(|bhi_r);

   // Lowest matching entry and lowest empty entry.
   always_comb begin
      fidx = '0;
      nidx = '0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (hitv[i]) fidx = IW'(i);
         if (!ent_r[i][0]) nidx = IW'(i);
      end
   end

   // Read mux over the register map or the data array.
   always_comb begin
      rdv = '0;
      if (a_r[srch_pkg::F_SP]) rdv = ent_r[ad[IW-1:0]];
      else if (ad < srch_pkg::A_MSKA) rdv = cmp_r[bk][ad[4:0]];
      else if (srch_pkg::is_msk(ad)) rdv = msk_r[bk][srch_pkg::msk_idx(ad)];
      else if (ad[6:3] == srch_pkg::A_HIT[6:3]) rdv = hit_r[bk][ad[2:0]];
      else if (ad == srch_pkg::A_CTL) rdv = ctl_r[bk];
      else if (ad == srch_pkg::A_INF) rdv = W'(DEVICE_INFORMATION_ID);
      else if (ad == srch_pkg::A_BRD) rdv = brd_r[bk];
      else if (ad == srch_pkg::A_BWR) rdv = bwr_r[bk];
      else if (ad == srch_pkg::A_NFA) rdv = W'(nidx);
   end

   // ---------------------------------------------------------------------
   // Register banks
   // ---------------------------------------------------------------------
   // Writable control registers, one copy per bank.
   always_ff @(posedge i_core_clk) begin
      if (rst) begin
         ctl_r <= '{default: srch_pkg::CTL_RST};
         brd_r <= '{default: '0};
         bwr_r <= '{default: '0};
      end else if (pend_r && code == srch_pkg::C_WR && sel && !a_r[srch_pkg::F_SP]) begin
         if (ad == srch_pkg::A_CTL) ctl_r[bk] <= dq_r;
         else if (ad == srch_pkg::A_BRD) brd_r[bk] <= dq_r;
         else if (ad == srch_pkg::A_BWR) bwr_r[bk] <= dq_r;
      end
   end

   // Mask storage in two address windows.
   always_ff @(posedge i_core_clk) begin
      if (pend_r && code == srch_pkg::C_WR && sel && !a_r[srch_pkg::F_SP] && srch_pkg::is_msk(ad)) begin
         msk_r[bk][srch_pkg::msk_idx(ad)] <= dq_r;
      end
   end

   // Each search keeps its two comparands for a later learn.
   always_ff @(posedge i_core_clk) begin
      if (pend_r && code == srch_pkg::C_SR) begin
         cmp_r[bk][{op_r[9:6], 1'b0}] <= a_r;
         cmp_r[bk][{op_r[9:6], 1'b1}] <= dq_r;
      end
   end

   // Hit index updates on any local hit; valid only for the global winner.
   always_ff @(posedge i_core_clk) begin
      if (rst) begin
         hit_r <= '{default: '{default: '0}};
      end else if (pend_r && code == srch_pkg::C_SR && any_hit) begin
         hit_r[bk][op_r[8:6]] <= W'(fidx) | (W'(winner) << srch_pkg::B_HVAL);
      end
   end

   // Data array: masked writes and learns into the first empty entry.
   always_ff @(posedge i_core_clk) begin
      if (rst) begin
         ent_r <= '{default: '0};
      end else if (pend_r && sel && a_r[srch_pkg::F_SP] && code == srch_pkg::C_WR) begin
         ent_r[ad[IW-1:0]] <= (ent_r[ad[IW-1:0]] & ~m_even) | (dq_r & m_even);
      end else if (pend_r && code == srch_pkg::C_LN && !own_full) begin
         ent_r[nidx] <= cmp_r[bk][{op_r[9:6], 1'b0}] | W'(1);
      end
   end

   // ---------------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------------
   // One-cycle read answer; broadcast only from the last member.
   always_ff @(posedge i_core_clk) begin
      if (rst) begin
         dqo_r  <= '0;
         dqoe_r <= 1'b0;
         ack_r  <= 1'b0;
      end else begin
         dqoe_r <= rsp;
         ack_r  <= rsp;
         dqo_r  <= rdv;
      end
   end
   assign bus.d_dq     = dqo_r;
   assign bus.d_dq_oe  = dqoe_r;
   assign bus.d_ack    = ack_r;
   assign bus.d_ack_oe = ack_r;

   // Cascade outputs; the hit outputs are forced low while the device is disabled.
   always_ff @(posedge i_core_clk) begin
      if (rst) begin
         o_local_hit_out  <= '0;
         o_block_hit_out  <= '0;
         o_full_chain_out <= '0;
         o_table_full     <= 1'b0;
      end else begin
         o_local_hit_out  <= {2{en && pend_r && code == srch_pkg::C_SR && any_hit}};
         o_block_hit_out  <= {3{en && LAST_IN_BLK && pend_r && code == srch_pkg::C_SR
                                && (any_hit || |lhi_r[6:1])}};
         o_full_chain_out <= {2{own_full}};
         o_table_full     <= own_full && &(fi_r[6:1] | ~FULL_IN_MASK[6:1]);
      end
   end

   // SRAM bus: winner drives, else the default driver parks.
   always_ff @(posedge i_core_clk) begin
      if (rst) begin
         o_sram_addr_out <= '1;
         o_sram_ce_n     <= 1'b1;
         o_sram_we_n     <= 1'b1;
         o_sram_ale_n    <= 1'b1;
         o_sram_bus_oe   <= 1'b0;
         o_sram_oe_n     <= 1'b1;
         o_sram_oe_n_oe  <= 1'b0;
      end else begin
         o_sram_addr_out <= (en && winner) ? srch_pkg::SA_W'(fidx) : '1;
         o_sram_ce_n     <= !(en && winner);
         o_sram_we_n     <= 1'b1;
         o_sram_ale_n    <= !(en && winner);
         o_sram_bus_oe   <= en && (winner || drv);
         o_sram_oe_n     <= !(en && winner && drv);
         o_sram_oe_n_oe  <= en && drv;
      end
   end

   // Internal clock phase from the selected source.
   clk_phase_gen u_clk (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (rst),
      .i_src_sel  (bus.src_sel),
      .i_phase_n  (bus.phase_n),
      .o_int_clk  (o_int_clk)
   );
endmodule

/* src/srch_pkg.sv */
// Shared constants and helpers of the search engine and host.
package srch_pkg;
   // ---------------------------------------------------------------------
   // Widths and device register offsets
   // ---------------------------------------------------------------------
   localparam int         W      = 72;
   localparam int         SA_W   = 24;
   localparam logic [6:0] A_MSKA = 7'h20;
   localparam logic [6:0] A_HIT  = 7'h30;
   localparam logic [6:0] A_CTL  = 7'h38;
   localparam logic [6:0] A_INF  = 7'h39;
   localparam logic [6:0] A_BRD  = 7'h3a;
   localparam logic [6:0] A_BWR  = 7'h3b;
   localparam logic [6:0] A_NFA  = 7'h3c;
   localparam logic [6:0] A_MSKB = 7'h60;
   // Command codes and fields.
   localparam logic [1:0] C_RD   = 2'h0;
   localparam logic [1:0] C_WR   = 2'h1;
   localparam logic [1:0] C_SR   = 2'h2;
   localparam logic [1:0] C_LN   = 2'h3;
   localparam int         B_EN   = 1;
   localparam int         B_LAST = 7;
   localparam int         B_DRV  = 8;
   localparam int         B_HVAL = 31;
   localparam logic [W-1:0] CTL_RST = 72'h0004;
   localparam logic [3:0] BCAST  = 4'hf;
   // Cycle A address word fields.
   localparam int         F_SP   = 7;
   localparam int         F_ID   = 8;
   // ---------------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------------
   localparam real        LOCK_MS  = 0.5;
   localparam real        CLK_NS   = 40.0;
   localparam int         LOCK_CYC = int'($ceil(LOCK_MS * 1.0e6 / CLK_NS));
   localparam logic [15:0] X1_CYC  = 16'h0020;
   localparam logic [15:0] X2_CYC  = 16'h0040;
   localparam logic [15:0] ACK_WAIT = 16'h0008;
   // ---------------------------------------------------------------------
   // Host register offsets
   // ---------------------------------------------------------------------
   localparam logic [3:0] H_CTL = 4'h0;
   localparam logic [3:0] H_D0  = 4'h1;
   localparam logic [3:0] H_D1  = 4'h2;
   localparam logic [3:0] H_D2  = 4'h3;
   localparam logic [3:0] H_ST  = 4'h4;
   localparam logic [3:0] H_R0  = 4'h5;
   localparam logic [3:0] H_R1  = 4'h6;
   localparam logic [3:0] H_R2  = 4'h7;
   localparam logic [3:0] H_CFG = 4'h8;

   // True for an address in either mask window.
   function automatic logic is_msk(input logic [6:0] a);
      return (a[6:4] == A_MSKA[6:4]) || (a[6:4] == A_MSKB[6:4]);
   endfunction

   // Mask register number of a mask address.
   function automatic logic [4:0] msk_idx(input logic [6:0] a);
      return {a[6], a[3:0]};
   endfunction
endpackage

/* src/srch_if.sv */
// Command and data link between the host controller and the search engine.
interface srch_if;
   logic                   rst_n;
   logic                   cmd_v;
   logic [10:0]            cmd;
   logic                   src_sel;
   logic                   phase_n;
   logic [srch_pkg::W-1:0] h_dq;
   logic                   h_dq_oe;
   logic [srch_pkg::W-1:0] d_dq;
   logic                   d_dq_oe;
   logic                   d_ack;
   logic                   d_ack_oe;
   logic [srch_pkg::W-1:0] dq;
   logic                   ack;

   // Resolved data bus; acknowledge pulled low.
   assign dq  = d_dq_oe ? d_dq : (h_dq_oe ? h_dq : '0);
   assign ack = d_ack_oe & d_ack;

   modport dev  (input rst_n, cmd_v, cmd, src_sel, phase_n, dq,
                 output d_dq, d_dq_oe, d_ack, d_ack_oe);
   modport host (output rst_n, cmd_v, cmd, src_sel, phase_n, h_dq, h_dq_oe,
                 input dq, ack);
endinterface

/* src/clk_phase_gen.sv */
// Internal clock phase generator of the search engine.
module clk_phase_gen (
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_sys_rst,
   // Clock source controls
   input  wire logic i_src_sel,
   input  wire logic i_phase_n,
   // Internal clock phase
   output logic      o_int_clk
);
   // Phase input in double-rate mode; toggling in single-rate mode.
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_int_clk <= 1'b0;
      end else if (!i_src_sel) begin
         o_int_clk <= !i_phase_n;
      end else begin
         o_int_clk <= !o_int_clk;
      end
   end
endmodule

/* src/srch_host.sv */
// Host end: software registers turned into engine commands.
module srch_host #(
   parameter int LOCK_CYC = srch_pkg::LOCK_CYC
) (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   // Software register port
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   // Engine link
   srch_if.host             bus
);
   localparam int W = srch_pkg::W;
   typedef enum logic [2:0] {S_RST, S_XTRA, S_IDLE, S_A, S_B, S_WAIT} st_t;

   st_t          st_r;
   logic [31:0]  ctl_r;
   logic [W-1:0] dat_r, rdat_r, hdq_r;
   logic         cfg_r, ph_r, rstn_r, cv_r, hoe_r, rdok_r, sec_r;
   logic [10:0]  cmd_r;
   logic [15:0]  cnt_r;
   logic         mwr;

   // Mask writes repeat to the partner register.
   assign mwr = ctl_r[1:0] == srch_pkg::C_WR && !ctl_r[18] && srch_pkg::is_msk(ctl_r[17:11]);

   // ---------------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------------
   // Data words and clock source configuration.
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         dat_r <= '0;
         cfg_r <= 1'b0;
      end else if (i_wr) begin
         if (i_addr == srch_pkg::H_D0) dat_r[31:0] <= i_wdata;
         else if (i_addr == srch_pkg::H_D1) dat_r[63:32] <= i_wdata;
         else if (i_addr == srch_pkg::H_D2) dat_r[W-1:64] <= i_wdata[W-65:0];
         else if (i_addr == srch_pkg::H_CFG) cfg_r <= i_wdata[0];
      end
   end

   // Read data stand one cycle after the strobe and only then.
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || !i_rd) begin
         o_rdata <= '0;
      end else if (i_addr == srch_pkg::H_CTL) o_rdata <= ctl_r;
      else if (i_addr == srch_pkg::H_ST) o_rdata <= {29'h0000_0000, rdok_r, st_r != S_RST && st_r != S_XTRA,
                                                     st_r != S_IDLE};
      else if (i_addr == srch_pkg::H_R0) o_rdata <= rdat_r[31:0];
      else if (i_addr == srch_pkg::H_R1) o_rdata <= rdat_r[63:32];
      else if (i_addr == srch_pkg::H_R2) o_rdata <= {24'h00_0000, rdat_r[W-1:64]};
      else if (i_addr == srch_pkg::H_CFG) o_rdata <= {31'h0000_0000, cfg_r};
      else o_rdata <= '0;
   end

   // Phase toggles in double-rate mode, grounded otherwise.
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || cfg_r) ph_r <= 1'b0;
      else ph_r <= !ph_r;
   end

   // ---------------------------------------------------------------------
   // Command sequencer
   // ---------------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_r   <= S_RST;
         cnt_r  <= 16'(LOCK_CYC);
         rstn_r <= 1'b0;
         cv_r   <= 1'b0;
         hoe_r  <= 1'b0;
         cmd_r  <= '0;
         hdq_r  <= '0;
         ctl_r  <= '0;
         rdat_r <= '0;
         rdok_r <= 1'b0;
         sec_r  <= 1'b0;
      end else begin
         case (st_r)
            S_RST: begin
               // Reset held low through the lock time, then extra cycles by mode.
               if (cnt_r == '0) begin
                  rstn_r <= 1'b1;
                  cnt_r  <= cfg_r ? srch_pkg::X1_CYC : srch_pkg::X2_CYC;
                  st_r   <= S_XTRA;
               end else cnt_r <= cnt_r - 16'h0001;
            end
            S_XTRA: begin
               if (cnt_r == '0) st_r <= S_IDLE;
               else cnt_r <= cnt_r - 16'h0001;
            end
            S_IDLE: begin
               if (i_wr && i_addr == srch_pkg::H_CTL && i_wdata[31]) begin
                  ctl_r <= i_wdata;
                  sec_r <= 1'b0;
                  st_r  <= S_A;
               end
            end
            S_A: begin
               // Code 1111 broadcasts: fifteen engines addressable.
               cv_r  <= 1'b1;
               hoe_r <= 1'b1;
               cmd_r <= ctl_r[10:0];
               hdq_r <= (ctl_r[1:0] == srch_pkg::C_SR || ctl_r[1:0] == srch_pkg::C_LN) ? dat_r
                        : W'({ctl_r[22:19], ctl_r[18], ctl_r[17:11]});
               st_r  <= S_B;
            end
            S_B: begin
               cv_r  <= 1'b0;
               hoe_r <= ctl_r[1:0] != srch_pkg::C_RD;
               hdq_r <= dat_r;
               if (ctl_r[1:0] == srch_pkg::C_RD) begin
                  cnt_r  <= srch_pkg::ACK_WAIT;
                  rdok_r <= 1'b0;
                  st_r   <= S_WAIT;
               end else if (mwr && !sec_r) begin
                  ctl_r[11] <= !ctl_r[11];
                  sec_r     <= 1'b1;
                  st_r      <= S_A;
               end else st_r <= S_IDLE;
            end
            S_WAIT: begin
               hoe_r <= 1'b0;
               if (bus.ack) begin
                  rdat_r <= bus.dq;
                  rdok_r <= 1'b1;
                  st_r   <= S_IDLE;
               end else if (cnt_r == '0) st_r <= S_IDLE;
               else cnt_r <= cnt_r - 16'h0001;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // Link outputs straight from flip-flops.
   assign bus.rst_n   = rstn_r;
   assign bus.cmd_v   = cv_r;
   assign bus.cmd     = cmd_r;
   assign bus.h_dq    = hdq_r;
   assign bus.h_dq_oe = hoe_r;
   assign bus.src_sel = cfg_r;
   assign bus.phase_n = ph_r;
endmodule

/* tb/srch_link_checker.sv */
// Concurrent checks on the host to engine link.
module srch_link_checker (
   // Clock and reset
   input wire logic        i_core_clk,
   input wire logic        i_sys_rst,
   // Link signals
   input wire logic        rst_n,
   input wire logic        cmd_v,
   input wire logic [10:0] cmd,
   input wire logic        src_sel,
   input wire logic        phase_n,
   input wire logic        h_dq_oe,
   input wire logic        d_dq_oe,
   input wire logic        ack
);
   // ------------------------------------------------------------
   // Request sequences and link properties
   // ------------------------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);
   // Cycle A of a read and of a search.
   sequence s_rd_a;
      cmd_v && cmd[1:0] == srch_pkg::C_RD;
   endsequence
   sequence s_sr_a;
      cmd_v && cmd[1:0] == srch_pkg::C_SR;
   endsequence
   a_ack_from_read: assert property (ack |-> $past(cmd_v, 3) && $past(cmd[1:0], 3) == srch_pkg::C_RD)
      else $error("stray ack");
   a_ack_one_cycle: assert property (ack |=> !ack)
      else $error("long ack");
   a_data_with_ack: assert property (d_dq_oe |-> ack)
      else $error("data without ack");
   a_no_bus_clash: assert property (!(d_dq_oe && h_dq_oe))
      else $error("bus clash");
   a_cmd_one_pulse: assert property (cmd_v |-> h_dq_oe ##1 !cmd_v)
      else $error("bad cycle A");
   a_read_b_idle: assert property (s_rd_a |=> !h_dq_oe)
      else $error("host drives read B");
   a_search_b_data: assert property (s_sr_a |=> h_dq_oe)
      else $error("no comparand in B");
   a_single_rate: assert property (src_sel && $past(src_sel) |-> !phase_n)
      else $error("phase in single rate");
   a_phase_toggle: assert property (!src_sel && $past(!src_sel) && $past(!i_sys_rst) |-> phase_n != $past(phase_n))
      else $error("phase stuck");
   a_lock_hold: assert property ($past(i_sys_rst) |-> !rst_n [*8])
      else $error("early engine reset");
endmodule

/* tb/search_register_cascade_ctrl_tb.sv */
// Bench joining host and search engine.
module search_register_cascade_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Stimulus, counters and instances
   // ------------------------------------------------------------
   logic        i_core_clk = 1'b0;
   logic        i_sys_rst  = 1'b1;
   logic [3:0]  i_addr     = 4'h0;
   logic [31:0] i_wdata    = 32'h0000_0000;
   logic        i_wr       = 1'b0;
   logic        i_rd       = 1'b0;
   logic [31:0] o_rdata;
   logic [1:0]  local_hit_out;
   logic [31:0] seed       = 32'h0001_7b68;
   int          errors     = 0;
   int          compares   = 0;
   int          hits       = 0;
   srch_if u_srch_if ();
   srch_host #(.LOCK_CYC(20)) u_srch_host (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .bus(u_srch_if.host));
   srch_dev u_srch_dev (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .bus(u_srch_if.dev), .i_position(5'h06),
      .i_local_hit_in(7'h00), .i_block_hit_in(3'h0), .i_full_chain_in(7'h00), .o_local_hit_out(local_hit_out),
      .o_block_hit_out(), .o_full_chain_out(), .o_table_full(), .o_sram_addr_out(), .o_sram_ce_n(),
      .o_sram_we_n(), .o_sram_ale_n(), .o_sram_bus_oe(), .o_sram_oe_n(), .o_sram_oe_n_oe(), .o_int_clk());
   srch_link_checker u_srch_link_checker (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .rst_n(u_srch_if.rst_n),
      .cmd_v(u_srch_if.cmd_v), .cmd(u_srch_if.cmd), .src_sel(u_srch_if.src_sel), .phase_n(u_srch_if.phase_n),
      .h_dq_oe(u_srch_if.h_dq_oe), .d_dq_oe(u_srch_if.d_dq_oe), .ack(u_srch_if.ack));
   // Clock and local hit pulse count.
   always #20 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) if (|local_hit_out) hits++;
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Xorshift source of repeatable random values.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Builds a host command word.
   function automatic logic [31:0] cw(logic [1:0] k, logic [6:0] ra, logic ar, logic [3:0] p, logic [3:0] m);
      return {9'h000, p, ar, ra, 1'b0, 4'h0, m, k};
   endfunction
   // Register port write and read.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Starts an engine command and waits for idle.
   task automatic op(input logic [31:0] c, input logic [71:0] d);
      logic [31:0] s;
      for (int k = 0; k < 3; k++) wr(4'(srch_pkg::H_D0 + k), 32'(d >> 32 * k));
      wr(srch_pkg::H_CTL, c | 32'h8000_0000);
      for (int i = 0; i < 20; i++) begin
         rd(srch_pkg::H_ST, s);
         if (s[0] === 1'b0) break;
      end
      chk({31'h0, s[0]}, 32'h0000_0000);
   endtask
   // Reads an engine register and checks it.
   task automatic dchk(input logic [31:0] c, input logic [71:0] e, input logic ok);
      logic [31:0] r;
      op(c | 32'(srch_pkg::C_RD), 72'h0);
      rd(srch_pkg::H_ST, r);
      chk({31'h0, r[2]}, {31'h0, ok});
      if (ok) begin
         for (int k = 0; k < 3; k++) begin
            rd(4'(srch_pkg::H_R0 + k), r);
            chk(r, 32'(e >> 32 * k));
         end
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios and watchdog
   // ------------------------------------------------------------
   initial begin
      #400us;
      errors++;
      final_report();
   end
   initial begin
      logic [31:0] r;
      logic [71:0] v;
      logic [3:0]  n;
      repeat (8) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      wr(srch_pkg::H_CFG, 32'h0000_0000);
      for (int i = 0; i < 60; i++) begin
         rd(srch_pkg::H_ST, r);
         if (r[1] === 1'b1) break;
      end
      chk({31'h0, r[1]}, 32'h0000_0001);
      rd(4'hf, r);
      chk(r, 32'h0000_0000);
      $display("test reset done");
      op(cw(srch_pkg::C_WR, srch_pkg::A_CTL, 1'b0, 4'h3, 4'h0), 72'h186);
      dchk(cw(2'h0, srch_pkg::A_CTL, 1'b0, 4'h3, 4'h0), 72'h186, 1'b1);
      dchk(cw(2'h0, srch_pkg::A_CTL, 1'b0, srch_pkg::BCAST, 4'h0), 72'h186, 1'b1);
      dchk(cw(2'h0, srch_pkg::A_CTL, 1'b0, 4'h5, 4'h0), 72'h0, 1'b0);
      $display("test control done");
      for (int i = 0; i < 4; i++) begin
         n = 4'(rnd());
         v = 72'({rnd(), rnd(), rnd()});
         op(cw(srch_pkg::C_WR, {n[3], 2'b10, n[2:0], 1'b0}, 1'b0, 4'h3, 4'h0), v);
         dchk(cw(2'h0, {n[3], 2'b10, n[2:0], 1'b0}, 1'b0, 4'h3, 4'h0), v, 1'b1);
         dchk(cw(2'h0, {n[3], 2'b10, n[2:0], 1'b1}, 1'b0, 4'h3, 4'h0), v, 1'b1);
      end
      $display("test masks done");
      op(cw(srch_pkg::C_WR, 7'h20, 1'b0, 4'h3, 4'h0), '1);
      op(cw(srch_pkg::C_WR, 7'h22, 1'b0, 4'h3, 4'h0), ~72'h20);
      v = 72'({rnd(), rnd(), rnd()}) | 72'h1;
      op(cw(srch_pkg::C_WR, 7'h02, 1'b1, 4'h3, 4'h0), v);
      op(cw(srch_pkg::C_WR, 7'h02, 1'b1, 4'h3, 4'h1), v ^ 72'h20);
      dchk(cw(2'h0, 7'h02, 1'b1, 4'h3, 4'h0), v, 1'b1);
      op(cw(srch_pkg::C_SR, 7'h00, 1'b0, 4'h3, 4'h0), v);
      dchk(cw(2'h0, 7'h00, 1'b0, 4'h3, 4'h0), v, 1'b1);
      dchk(cw(2'h0, srch_pkg::A_HIT, 1'b0, 4'h3, 4'h0), 72'h8000_0002, 1'b1);
      op(cw(srch_pkg::C_SR, 7'h00, 1'b0, 4'h3, 4'h1), v ^ 72'h20);
      op(cw(srch_pkg::C_SR, 7'h00, 1'b0, 4'h3, 4'h0), v ^ 72'h20);
      chk(32'(hits), 32'h0000_0002);
      $display("test search done");
      wr(srch_pkg::H_CFG, 32'h0000_0001);
      rd(srch_pkg::H_CFG, r);
      chk(r, 32'h0000_0001);
      $display("test single rate done");
      final_report();
   end
endmodule
